// ==== hdl/tcs_pkg.sv ====
// package: register map, field positions and reset values of the timer channel
package tcs_pkg;
   // ****************************************
   // register offsets (byte addresses)
   // ****************************************
   localparam logic [3:0] ADDR_CLOCK_GATE = 4'h0;
   localparam logic [3:0] ADDR_PRESCALER = 4'h1;
   localparam logic [3:0] ADDR_MODE_HIGH = 4'h2;
   localparam logic [3:0] ADDR_MODE_LOW = 4'h3;
   localparam logic [3:0] ADDR_RELOAD_LO = 4'h4;
   localparam logic [3:0] ADDR_RELOAD_HI = 4'h5;
   localparam logic [3:0] ADDR_CONTROL = 4'h6;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h7;
   localparam logic [3:0] ADDR_IRQ_CLEAR = 4'h8;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h9;
   localparam logic [3:0] ADDR_COUNT_LO = 4'hA;
   localparam logic [3:0] ADDR_COUNT_HI = 4'hB;
   // ****************************************
   // field positions
   // ****************************************
   localparam int GATE_BIT = 0;
   localparam int CHAN_PICK_BIT = 7;
   localparam int SOURCE_BIT = 4;
   localparam int START_CMD_BIT = 0;
   localparam int STOP_CMD_BIT = 1;
   localparam int EDGE_SEL_LSB = 6;
   // ****************************************
   // reset values
   // ****************************************
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   // ****************************************
   // start trigger codes
   // ****************************************
   localparam logic [2:0] TRIG_SOFT = 3'h0;
   localparam logic [2:0] TRIG_EDGE = 3'h1;
   localparam logic [2:0] TRIG_BOTH = 3'h2;
   localparam logic [2:0] TRIG_MASTER = 3'h4;
   // interrupt status bits
   localparam int IRQ_TICK_BIT = 0;
   localparam int IRQ_BADCFG_BIT = 1;
   // mode register fields carried together
   typedef struct packed {
      logic chan_clock_pick;
      logic count_source_pick;
      logic [2:0] start_trigger_sel;
      logic [1:0] edge_sel;
      logic mode_low_bit;
   } tcs_mode_t;
endpackage

// ==== hdl/tcs_prescaler.sv ====
// power-of-two prescaler making the two operation clock enables
`timescale 1ns/10ps
module tcs_prescaler
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   // divide selections
   input wire logic [3:0] sel_a,
   input wire logic [3:0] sel_b,
   // one-cycle enables
   output logic op_clock_a,
   output logic op_clock_b
);
   logic [14:0] div;

   // free counter, held while the unit clock is gated
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         div <= 15'h0000;
      else if (run)
         div <= div + 15'h0001;
   end

   // tick when the low sel bits of the counter are all ones
   function automatic logic tick(input logic [14:0] cnt, input logic [3:0] sel);
      logic [14:0] mask;
      mask = 15'((16'h0001 << sel) - 16'h0001);
      return (cnt & mask) == mask;
   endfunction

   assign op_clock_a = run && tick(div, sel_a); // RULE2
   assign op_clock_b = run && tick(div, sel_b);
endmodule // tcs_prescaler

// ==== hdl/tcs_channel.sv ====
// timer channel 0: clock gate, prescaler, count clock pick, interval counter
// Behaviour
// RULE1: gate bit 0 stops (0) or supplies (1) the timer unit clock.
// RULE2: first operation clock is system clock divided by 2 to prescaler bits 3..0.
// RULE3: mode high bit 7 picks first (0) or second (1) operation clock.
// RULE4: bit 4 counts operation clock (0) or valid timer input edges (1).
// RULE5: start trigger 000 soft, 001 valid edge, 010 both edges, 100 master.
// RULE6: interval mode counts down; lowest mode bit 1 interrupts at start.
// RULE7: interrupt every reload value plus one count clock cycles.
`timescale 1ns/10ps
module tcs_channel
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // pins and events
   input wire logic TIMER_INPUT_PIN,
   input wire logic MASTER_IRQ,
   output logic CHANNEL_INTERRUPT,
   output logic IRQ
);
   // ****************************************
   // registers
   // ****************************************
   logic [7:0] peripheral_clock_gate;
   logic [7:0] timer_prescaler_select;
   tcs_pkg::tcs_mode_t mode;
   logic [15:0] compare_reload_value;
   logic [15:0] count;
   logic running;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;
   logic pin_s1, pin_s2, pin_s3;
   logic op_clock_a, op_clock_b;
   logic channel_op_clock, channel_count_clock;
   logic gate, rise, fall, valid_edge, trig_ok, trig_bad, start_evt, stop_evt, tick;
   logic [7:0] next_rdata;

   assign gate = peripheral_clock_gate[tcs_pkg::GATE_BIT]; // RULE1

   tcs_prescaler u_pre
   (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .run(gate),
      .sel_a(timer_prescaler_select[3:0]),
      .sel_b(timer_prescaler_select[7:4]),
      .op_clock_a(op_clock_a),
      .op_clock_b(op_clock_b)
   );

   // ****************************************
   // pin synchroniser and edge detection
   // ****************************************
   // two flops before use; third flop only for edge compare
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_B)
      begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
      end
      else
      begin
         pin_s1 <= TIMER_INPUT_PIN;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   assign rise = pin_s2 && !pin_s3;
   assign fall = !pin_s2 && pin_s3;

   // valid edge per edge select field: 00 fall, 01 rise, else both
   always_comb
   begin
      unique case (mode.edge_sel)
         2'b00: valid_edge = fall;
         2'b01: valid_edge = rise;
         default: valid_edge = rise || fall;
      endcase
   end

   // ****************************************
   // count clock selection
   // ****************************************
   assign channel_op_clock = mode.chan_clock_pick ? op_clock_b : op_clock_a; // RULE3
   // edge counting also needs the unit clock supplied
   assign channel_count_clock = gate && (mode.count_source_pick ? valid_edge
                                                                 : channel_op_clock); // RULE4

   // start trigger decode; prohibited codes raise trig_bad and trigger nothing
   always_comb
   begin
      trig_ok = 1'b0;
      trig_bad = 1'b0;
      unique case (mode.start_trigger_sel)
         tcs_pkg::TRIG_SOFT: trig_ok = 1'b0; // RULE5
         tcs_pkg::TRIG_EDGE: trig_ok = valid_edge; // RULE5
         tcs_pkg::TRIG_BOTH: trig_ok = rise || fall; // RULE5
         tcs_pkg::TRIG_MASTER: trig_ok = MASTER_IRQ; // RULE5
         default: trig_bad = 1'b1; // RULE5
      endcase
   end

   assign start_evt = gate && ((WR && ADDR == tcs_pkg::ADDR_CONTROL
                               && WDATA[tcs_pkg::START_CMD_BIT]) || trig_ok);
   assign stop_evt = WR && ADDR == tcs_pkg::ADDR_CONTROL && WDATA[tcs_pkg::STOP_CMD_BIT];

   // ****************************************
   // interval down counter
   // ****************************************
   // start loads reload value; reaching zero on a count clock reloads and ticks,
   // so the period is reload plus one count clocks
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_B)
      begin
         count <= tcs_pkg::RESET_WORD;
         running <= 1'b0;
      end
      else if (stop_evt || !gate)
         running <= 1'b0;
      else if (start_evt)
      begin
         count <= compare_reload_value; // RULE7
         running <= 1'b1;
      end
      else if (running && channel_count_clock)
      begin
         if (count == 16'h0000)
            count <= compare_reload_value; // RULE7
         else
            count <= count - 16'h0001; // RULE6
      end
   end

   // interrupt at zero, or at start when the lowest mode bit is set
   assign tick = (running && channel_count_clock && count == 16'h0000 && !start_evt)
                 || (start_evt && mode.mode_low_bit); // RULE6

   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_B)
         CHANNEL_INTERRUPT <= 1'b0;
      else
         CHANNEL_INTERRUPT <= tick; // RULE7
   end

   // ****************************************
   // register writes
   // ****************************************
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_B)
      begin
         peripheral_clock_gate <= tcs_pkg::RESET_BYTE;
         timer_prescaler_select <= tcs_pkg::RESET_BYTE;
         mode <= '0;
         compare_reload_value <= tcs_pkg::RESET_WORD;
         irq_enable <= 2'b00;
      end
      else if (WR)
      begin
         unique case (ADDR)
            tcs_pkg::ADDR_CLOCK_GATE: peripheral_clock_gate <= WDATA;
            tcs_pkg::ADDR_PRESCALER: timer_prescaler_select <= WDATA;
            tcs_pkg::ADDR_MODE_HIGH:
            begin
               mode.chan_clock_pick <= WDATA[tcs_pkg::CHAN_PICK_BIT];
               mode.count_source_pick <= WDATA[tcs_pkg::SOURCE_BIT];
               mode.start_trigger_sel <= WDATA[2:0];
            end
            tcs_pkg::ADDR_MODE_LOW:
            begin
               mode.edge_sel <= WDATA[tcs_pkg::EDGE_SEL_LSB +: 2];
               mode.mode_low_bit <= WDATA[0];
            end
            tcs_pkg::ADDR_RELOAD_LO: compare_reload_value[7:0] <= WDATA;
            tcs_pkg::ADDR_RELOAD_HI: compare_reload_value[15:8] <= WDATA;
            tcs_pkg::ADDR_IRQ_ENABLE: irq_enable <= WDATA[1:0];
            default: ;
         endcase
      end
   end

   // sticky status: a set in the clear cycle wins
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_B)
         irq_status <= 2'b00;
      else
      begin
         for (int i = 0; i < 2; i++)
         begin
            if ((i == tcs_pkg::IRQ_TICK_BIT && tick)
                || (i == tcs_pkg::IRQ_BADCFG_BIT && trig_bad))
               irq_status[i] <= 1'b1;
            else if (WR && ADDR == tcs_pkg::ADDR_IRQ_CLEAR && WDATA[i])
               irq_status[i] <= 1'b0;
         end
      end
   end

   assign IRQ = |(irq_status & irq_enable);

   // ****************************************
   // read data, one cycle after the strobe
   // ****************************************
   always_comb
   begin
      next_rdata = 8'h00;
      unique case (ADDR)
         tcs_pkg::ADDR_CLOCK_GATE: next_rdata = peripheral_clock_gate;
         tcs_pkg::ADDR_PRESCALER: next_rdata = timer_prescaler_select;
         tcs_pkg::ADDR_MODE_HIGH: next_rdata = {mode.chan_clock_pick, 2'b00,
                                                mode.count_source_pick, 1'b0,
                                                mode.start_trigger_sel};
         tcs_pkg::ADDR_MODE_LOW: next_rdata = {mode.edge_sel, 5'b00000, mode.mode_low_bit};
         tcs_pkg::ADDR_RELOAD_LO: next_rdata = compare_reload_value[7:0];
         tcs_pkg::ADDR_RELOAD_HI: next_rdata = compare_reload_value[15:8];
         tcs_pkg::ADDR_CONTROL: next_rdata = {7'b0000000, running};
         tcs_pkg::ADDR_IRQ_STATUS: next_rdata = {6'b000000, irq_status};
         tcs_pkg::ADDR_IRQ_ENABLE: next_rdata = {6'b000000, irq_enable};
         tcs_pkg::ADDR_COUNT_LO: next_rdata = count[7:0];
         tcs_pkg::ADDR_COUNT_HI: next_rdata = count[15:8];
         default: next_rdata = 8'h00;
      endcase
   end

   // data stands only in the cycle after the read strobe
   always_ff @(posedge CORE_CLK)
   begin
      if (!RST_B)
         RDATA <= 8'h00;
      else if (RD)
         RDATA <= next_rdata;
      else
         RDATA <= 8'h00;
   end
endmodule // tcs_channel

// ==== tb/tcs_channel_monitor.sv ====
// checker: port-level assertions for the timer channel
`timescale 1ns/10ps
module tcs_channel_monitor
(
   // clock and reset
   input wire logic CORE_CLK,
   input wire logic RST_B,
   // register port
   input wire logic [3:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   // pins and events
   input wire logic TIMER_INPUT_PIN,
   input wire logic MASTER_IRQ,
   input wire logic CHANNEL_INTERRUPT,
   input wire logic IRQ
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RST_B);
   // write then read of the same register, no gap
   sequence s_wr(a);
      WR && ADDR == a;
   endsequence
   sequence s_rd(a);
      RD && ADDR == a;
   endsequence
   // gate written off, then left alone for five cycles
   sequence s_gate_off;
      WR && ADDR == tcs_pkg::ADDR_CLOCK_GATE && !WDATA[0] ##1 !WR [*5];
   endsequence
   // a later gate-on write may legally restart the channel, so only the quiet span is checked
   property p_gate_off;
      s_gate_off |-> !CHANNEL_INTERRUPT && !$past(CHANNEL_INTERRUPT, 1)
         && !$past(CHANNEL_INTERRUPT, 2) && !$past(CHANNEL_INTERRUPT, 3);
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("interrupt while gated off");
   property p_pre_back;
      s_wr(tcs_pkg::ADDR_PRESCALER) ##1 s_rd(tcs_pkg::ADDR_PRESCALER) |=> RDATA == $past(WDATA, 2);
   endproperty
   a_pre_back: assert property (p_pre_back)
      else $error("prescaler readback wrong");
   property p_mode_back;
      s_wr(tcs_pkg::ADDR_MODE_HIGH) ##1 s_rd(tcs_pkg::ADDR_MODE_HIGH)
         |=> (RDATA & 8'h97) == ($past(WDATA, 2) & 8'h97);
   endproperty
   a_mode_back: assert property (p_mode_back)
      else $error("mode readback wrong");
   property p_tick_seen;
      CHANNEL_INTERRUPT && !WR ##1 s_rd(tcs_pkg::ADDR_IRQ_STATUS) |=> RDATA[0];
   endproperty
   a_tick_seen: assert property (p_tick_seen)
      else $error("tick status missing");
   property p_rd_idle;
      !RD |=> RDATA == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data not idle");
   property p_unmapped;
      RD && ADDR > tcs_pkg::ADDR_COUNT_HI |=> RDATA == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   // status is sticky, so only a write can drop the level
   property p_irq_hold;
      IRQ && !WR |=> IRQ;
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("interrupt level dropped");
endmodule // tcs_channel_monitor
bind tcs_channel tcs_channel_monitor mon (.CORE_CLK(CORE_CLK), .RST_B(RST_B), .ADDR(ADDR),
   .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .TIMER_INPUT_PIN(TIMER_INPUT_PIN),
   .MASTER_IRQ(MASTER_IRQ), .CHANNEL_INTERRUPT(CHANNEL_INTERRUPT), .IRQ(IRQ));

// ==== tb/tb_top.sv ====
// testbench: register-level scenarios for the timer channel
`timescale 1ns/10ps
module tb_top;
   // ****************
   // signals and tasks
   // ****************
   localparam logic [3:0] gate = tcs_pkg::ADDR_CLOCK_GATE, pre = tcs_pkg::ADDR_PRESCALER;
   localparam logic [3:0] mh = tcs_pkg::ADDR_MODE_HIGH, ml = tcs_pkg::ADDR_MODE_LOW;
   localparam logic [3:0] ctl = tcs_pkg::ADDR_CONTROL, st = tcs_pkg::ADDR_IRQ_STATUS;
   logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b0, mirq = 1'b0, tog = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [1:0] ph = 2'h0;
   logic [7:0] wdata = 8'h00, rdata, v;
   logic cint, irq;
   int errors = 0, n_tests = 0, n;
   tcs_channel uut (.CORE_CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr),
      .RD(rd), .RDATA(rdata), .TIMER_INPUT_PIN(pin), .MASTER_IRQ(mirq),
      .CHANNEL_INTERRUPT(cint), .IRQ(irq));
   initial
   begin
      forever #12.5 clk = ~clk;
   end
   // input pin toggles every 4 cycles when enabled
   always @(posedge clk)
   begin
      ph <= ph + 2'h1;
      if (tog && ph == 2'h3)
         pin <= ~pin;
   end
   task automatic summarize;
      $display("errors %0d checks %0d", errors, n_tests);
      if (errors == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wrt(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
   endtask
   task automatic rdt(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // edges until the next interrupt pulse, bounded
   task automatic wint(output int c);
      c = 0;
      do
      begin
         @(posedge clk);
         wr <= 1'b0;
         #1 c++;
      end
      while (cint !== 1'b1 && c < 300);
      if (c >= 300)
      begin
         errors++;
         $display("mismatch at %0t: no interrupt", $time);
         summarize();
      end
   endtask
   // ****************
   // scenarios
   // ****************
   initial
   begin
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      for (int a = 0; a < 16; a++)
      begin
         rdt(4'(a), v);
         chk(v, tcs_pkg::RESET_BYTE);
      end
      wrt(pre, 8'hA5);
      rdt(pre, v);
      chk(v, 8'hA5);
      wrt(mh, 8'h90);
      rdt(mh, v);
      chk(v, 8'h90);
      wrt(tcs_pkg::ADDR_RELOAD_LO, 8'h02);
      wrt(ctl, 8'h01);
      rdt(ctl, v);
      chk(v, 8'h00);
      wrt(gate, 8'h01);
      wrt(pre, 8'h00);
      wrt(mh, 8'h00);
      wrt(tcs_pkg::ADDR_IRQ_ENABLE, 8'h01);
      wrt(ctl, 8'h01);
      wint(n);
      chk(8'(n > 2), 8'h01);
      wint(n);
      chk(8'(n), 8'h03);
      rdt(st, v);
      chk(v, 8'h01);
      chk({7'h0, irq}, 8'h01);
      wrt(tcs_pkg::ADDR_IRQ_ENABLE, 8'h00);
      rdt(st, v);
      chk(v, 8'h01);
      chk({7'h0, irq}, 8'h00);
      wrt(ctl, 8'h02);
      wrt(ml, 8'h01);
      wrt(ctl, 8'h01);
      wint(n);
      chk(8'(n < 3), 8'h01);
      wrt(pre, 8'h01);
      wint(n);
      wint(n);
      chk(8'(n), 8'h06);
      wrt(pre, 8'h21);
      wrt(mh, 8'h80);
      wint(n);
      wint(n);
      chk(8'(n), 8'h0C);
      wrt(mh, 8'h10);
      wrt(ml, 8'h40);
      wrt(tcs_pkg::ADDR_RELOAD_LO, 8'h01);
      tog <= 1'b1;
      wint(n);
      wint(n);
      wint(n);
      chk(8'(n), 8'h10);
      wrt(gate, 8'h00);
      n = 0;
      // a pulse launched at the gate-off edge itself is still legal
      @(posedge clk);
      wr <= 1'b0;
      repeat (40)
      begin
         @(posedge clk);
         #1 n += int'(cint);
      end
      chk(8'(n), 8'h00);
      tog <= 1'b0;
      wrt(gate, 8'h01);
      for (int c = 0; c < 8; c++)
      begin
         wrt(mh, 8'(c));
         wrt(tcs_pkg::ADDR_IRQ_CLEAR, 8'h03);
         rdt(st, v);
         chk(v & 8'h02, (c == 3 || c > 4) ? 8'h02 : 8'h00);
      end
      wrt(ctl, 8'h02);
      wrt(mh, 8'h04);
      @(posedge clk);
      wr <= 1'b0;
      mirq <= 1'b1;
      @(posedge clk);
      mirq <= 1'b0;
      wint(n);
      chk(8'(n < 20), 8'h01);
      summarize();
   end
endmodule // tb_top
